// *** bsf_pkg.sv ***
// Package of constants for the bit, shift and flag execution unit
package bsf_pkg;
	// ==========================================================
	// Operation codes
	typedef enum logic [4:0] {
		OP_NOP = 5'h00,
		OP_IO_BIT_SET = 5'h01,
		OP_IO_BIT_CLEAR = 5'h02,
		OP_LOGICAL_SHIFT_LEFT = 5'h03,
		OP_LOGICAL_SHIFT_RIGHT = 5'h04,
		OP_ROTATE_LEFT_CARRY = 5'h05,
		OP_ROTATE_RIGHT_CARRY = 5'h06,
		OP_ARITH_SHIFT_RIGHT = 5'h07,
		OP_NIBBLE_SWAP = 5'h08,
		OP_STATUS_BIT_SET = 5'h09,
		OP_STATUS_BIT_CLEAR = 5'h0a,
		OP_BIT_TO_FLAG_COPY = 5'h0b,
		OP_FLAG_TO_BIT_COPY = 5'h0c,
		OP_SIGN_FLAG_SET = 5'h0d,
		OP_SIGN_FLAG_CLEAR = 5'h0e,
		OP_OVERFLOW_FLAG_CLEAR = 5'h0f,
		OP_HALF_CARRY_SET = 5'h10,
		OP_HALF_CARRY_CLEAR = 5'h11,
		OP_INT_ENABLE = 5'h12,
		OP_INT_DISABLE = 5'h13,
		OP_SLEEP = 5'h14,
		OP_WATCHDOG_RESTART = 5'h15,
		OP_DEBUG_BREAK = 5'h16
	} bsf_op_e;
	// ==========================================================
	// Status register bit positions
	localparam int unsigned FLAG_C = 0;
	localparam int unsigned FLAG_Z = 1;
	localparam int unsigned FLAG_N = 2;
	localparam int unsigned FLAG_V = 3;
	localparam int unsigned FLAG_S = 4;
	localparam int unsigned FLAG_H = 5;
	localparam int unsigned FLAG_T = 6;
	localparam int unsigned FLAG_I = 7;
	// ==========================================================
	// Reset values and cycle counts
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [1:0] IO_BIT_CYCLES = 2'h2;
endpackage : bsf_pkg

// *** bsf_unit.sv ***
// Bit, shift and status flag execution unit of an 8-bit core
//
// Summary of operation
// RULE_01: I/O bit set forces addressed bit high, flags kept, two cycles.
// RULE_02: I/O bit clear forces addressed bit low, flags kept, two cycles.
// RULE_03: Left shift, zero into bit 0, updates Z C N V in one cycle.
// RULE_04: Right shift, zero into bit 7, updates Z C N V in one cycle.
// RULE_05: Rotate left through carry; old bit 7 to carry; one cycle.
// RULE_06: Rotate right through carry; old bit 0 to carry; one cycle.
// RULE_07: Arithmetic right shift keeps bit 7, updates Z C N V, one cycle.
// RULE_08: Nibble swap exchanges halves in one cycle, flags kept.
// RULE_09: Set any status bit by index or dedicated op, one cycle.
// RULE_10: Clear any status bit by index or dedicated op, one cycle.
// RULE_11: Overflow clear op clears V only, one cycle.
// RULE_12: Half carry set and clear ops touch H only, one cycle.
// RULE_13: Bit store copies selected source bit into T, one cycle.
// RULE_14: Bit load writes T into selected register bit, flags kept.
// RULE_15: Sleep issues in one cycle, flags kept, pulses sleep request.
// RULE_16: Watchdog restart takes one cycle, flags kept, pulses restart.
// RULE_17: Debug break only pulses debug request, flags kept.
// RULE_18: Interrupt enable and disable ops set or clear I only.
// RULE_19: No-op takes one cycle and changes nothing.
`timescale 1ns/1ps
module bsf_unit (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_valid,
	input wire logic [4:0] i_op,
	input wire logic [7:0] i_rd,
	input wire logic [2:0] i_bit,
	input wire logic [7:0] i_io_data,
	output logic o_ready,
	output logic o_done,
	output logic [7:0] o_result,
	output logic o_result_we,
	output logic [7:0] o_io_data,
	output logic o_io_we,
	output logic [7:0] o_status_register,
	output logic o_sleep_req,
	output logic o_watchdog_restart,
	output logic o_debug_break
);
	// ==========================================================
	// Sequencer
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_IO_WRITE = 2'b10
	} bsf_state_e;

	bsf_state_e state_reg;
	logic [7:0] status_reg;
	logic [7:0] status_next;
	logic [7:0] result_reg;
	logic [7:0] result_next;
	logic result_we_reg;
	logic result_we_next;
	logic [7:0] io_data_reg;
	logic io_we_reg;
	logic done_reg;
	logic sleep_reg;
	logic wdr_reg;
	logic brk_reg;
	logic [7:0] io_mod_reg;
	logic take;
	logic is_shift;
	logic [7:0] sh_val;
	logic sh_c;
	logic [7:0] bit_mask;
	bsf_pkg::bsf_op_e op;

	assign op = bsf_pkg::bsf_op_e'(i_op);
	assign o_ready = (state_reg == ST_IDLE);
	assign take = i_valid && o_ready;
	assign bit_mask = 8'h01 << i_bit;

	// I/O bit operations hold the unit busy for a second cycle
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_reg <= ST_IDLE;
			io_mod_reg <= bsf_pkg::REG_RESET;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					if (take && (op == bsf_pkg::OP_IO_BIT_SET)) begin
						state_reg <= ST_IO_WRITE;
						io_mod_reg <= i_io_data | bit_mask; // see RULE_01
					end else if (take && (op == bsf_pkg::OP_IO_BIT_CLEAR)) begin
						state_reg <= ST_IO_WRITE;
						io_mod_reg <= i_io_data & ~bit_mask; // see RULE_02
					end
				end
				ST_IO_WRITE: begin
					state_reg <= ST_IDLE;
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			io_data_reg <= bsf_pkg::REG_RESET;
			io_we_reg <= 1'b0;
		end else begin
			io_we_reg <= (state_reg == ST_IO_WRITE);
			if (state_reg == ST_IO_WRITE) begin
				io_data_reg <= io_mod_reg;
			end
		end
	end

	// ==========================================================
	// Shift and rotate datapath
	always_comb begin
		is_shift = 1'b1;
		sh_val = i_rd;
		sh_c = i_rd[0];
		case (op)
			bsf_pkg::OP_LOGICAL_SHIFT_LEFT: begin
				sh_val = {i_rd[6:0], 1'b0}; // see RULE_03
				sh_c = i_rd[7];
			end
			bsf_pkg::OP_LOGICAL_SHIFT_RIGHT: begin
				sh_val = {1'b0, i_rd[7:1]}; // see RULE_04
				sh_c = i_rd[0];
			end
			bsf_pkg::OP_ROTATE_LEFT_CARRY: begin
				sh_val = {i_rd[6:0], status_reg[bsf_pkg::FLAG_C]}; // see RULE_05
				sh_c = i_rd[7];
			end
			bsf_pkg::OP_ROTATE_RIGHT_CARRY: begin
				sh_val = {status_reg[bsf_pkg::FLAG_C], i_rd[7:1]}; // see RULE_06
				sh_c = i_rd[0];
			end
			bsf_pkg::OP_ARITH_SHIFT_RIGHT: begin
				sh_val = {i_rd[7], i_rd[7:1]}; // see RULE_07
				sh_c = i_rd[0];
			end
			default: begin
				is_shift = 1'b0;
			end
		endcase
	end

	// ==========================================================
	// Result and flag update
	always_comb begin
		status_next = status_reg;
		result_next = result_reg;
		result_we_next = 1'b0;
		if (take) begin
			if (is_shift) begin
				// V follows N xor C, S follows N xor V, as for every shift
				result_next = sh_val;
				result_we_next = 1'b1;
				status_next[bsf_pkg::FLAG_C] = sh_c;
				status_next[bsf_pkg::FLAG_Z] = (sh_val == 8'h00);
				status_next[bsf_pkg::FLAG_N] = sh_val[7];
				status_next[bsf_pkg::FLAG_V] = sh_val[7] ^ sh_c;
				status_next[bsf_pkg::FLAG_S] = sh_c;
			end
			case (op)
				bsf_pkg::OP_NIBBLE_SWAP: begin
					result_next = {i_rd[3:0], i_rd[7:4]}; // see RULE_08
					result_we_next = 1'b1;
				end
				bsf_pkg::OP_STATUS_BIT_SET: begin
					status_next[i_bit] = 1'b1; // see RULE_09
				end
				bsf_pkg::OP_STATUS_BIT_CLEAR: begin
					status_next[i_bit] = 1'b0; // see RULE_10
				end
				bsf_pkg::OP_SIGN_FLAG_SET: begin
					status_next[bsf_pkg::FLAG_S] = 1'b1; // see RULE_09
				end
				bsf_pkg::OP_SIGN_FLAG_CLEAR: begin
					status_next[bsf_pkg::FLAG_S] = 1'b0; // see RULE_10
				end
				bsf_pkg::OP_OVERFLOW_FLAG_CLEAR: begin
					status_next[bsf_pkg::FLAG_V] = 1'b0; // see RULE_11
				end
				bsf_pkg::OP_HALF_CARRY_SET: begin
					status_next[bsf_pkg::FLAG_H] = 1'b1; // see RULE_12
				end
				bsf_pkg::OP_HALF_CARRY_CLEAR: begin
					status_next[bsf_pkg::FLAG_H] = 1'b0; // see RULE_12
				end
				bsf_pkg::OP_BIT_TO_FLAG_COPY: begin
					status_next[bsf_pkg::FLAG_T] = i_rd[i_bit]; // see RULE_13
				end
				bsf_pkg::OP_FLAG_TO_BIT_COPY: begin
					result_next = i_rd;
					result_next[i_bit] = status_reg[bsf_pkg::FLAG_T]; // see RULE_14
					result_we_next = 1'b1;
				end
				bsf_pkg::OP_INT_ENABLE: begin
					status_next[bsf_pkg::FLAG_I] = 1'b1; // see RULE_18
				end
				bsf_pkg::OP_INT_DISABLE: begin
					status_next[bsf_pkg::FLAG_I] = 1'b0; // see RULE_18
				end
				default: begin
					// No-op, sleep, watchdog and break keep all state; see RULE_19
				end
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			status_reg <= bsf_pkg::STATUS_RESET;
			result_reg <= bsf_pkg::REG_RESET;
			result_we_reg <= 1'b0;
		end else begin
			status_reg <= status_next;
			result_reg <= result_next;
			result_we_reg <= result_we_next;
		end
	end

	// ==========================================================
	// Core control pulses and completion
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sleep_reg <= 1'b0;
			wdr_reg <= 1'b0;
			brk_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			sleep_reg <= take && (op == bsf_pkg::OP_SLEEP); // see RULE_15
			wdr_reg <= take && (op == bsf_pkg::OP_WATCHDOG_RESTART); // see RULE_16
			brk_reg <= take && (op == bsf_pkg::OP_DEBUG_BREAK); // see RULE_17
			done_reg <= (take && (op != bsf_pkg::OP_IO_BIT_SET)
				&& (op != bsf_pkg::OP_IO_BIT_CLEAR)) || (state_reg == ST_IO_WRITE);
		end
	end

	assign o_done = done_reg;
	assign o_result = result_reg;
	assign o_result_we = result_we_reg;
	assign o_io_data = io_data_reg;
	assign o_io_we = io_we_reg;
	assign o_status_register = status_reg;
	assign o_sleep_req = sleep_reg;
	assign o_watchdog_restart = wdr_reg;
	assign o_debug_break = brk_reg;

	// ==========================================================
	// Checks
	property p_io_set;
		@(posedge i_clk) disable iff (!i_rst_b)
		(take && op == bsf_pkg::OP_IO_BIT_SET) |->
			##2 (o_io_we && o_io_data == ($past(i_io_data, 2) | $past(bit_mask, 2))
			&& o_status_register == $past(status_reg, 2));
	endproperty
	a_io_set: assert property (p_io_set) else $error("io bit set wrong"); // see RULE_01

	property p_io_clear;
		@(posedge i_clk) disable iff (!i_rst_b)
		(take && op == bsf_pkg::OP_IO_BIT_CLEAR) |=>
			!o_ready ##1 (o_ready && o_done && o_io_we
			&& o_io_data == ($past(i_io_data, 2) & ~$past(bit_mask, 2)));
	endproperty
	a_io_clear: assert property (p_io_clear) else $error("io bit clear wrong"); // see RULE_02

	property p_lsl;
		@(posedge i_clk) disable iff (!i_rst_b)
		(take && op == bsf_pkg::OP_LOGICAL_SHIFT_LEFT) |=> (o_done
			&& o_result == {$past(i_rd[6:0]), 1'b0}
			&& o_status_register[bsf_pkg::FLAG_C] == $past(i_rd[7]));
	endproperty
	a_lsl: assert property (p_lsl) else $error("left shift wrong"); // see RULE_03

	property p_lsr;
		@(posedge i_clk) disable iff (!i_rst_b)
		(take && op == bsf_pkg::OP_LOGICAL_SHIFT_RIGHT) |=> (o_result[7] == 1'b0
			&& o_status_register[bsf_pkg::FLAG_Z] == (o_result == 8'h00)
			&& o_status_register[bsf_pkg::FLAG_C] == $past(i_rd[0]));
	endproperty
	a_lsr: assert property (p_lsr) else $error("right shift wrong"); // see RULE_04

	property p_rol;
		@(posedge i_clk) disable iff (!i_rst_b)
		(take && op == bsf_pkg::OP_ROTATE_LEFT_CARRY) |=>
			(o_result[0] == $past(status_reg[bsf_pkg::FLAG_C]));
	endproperty
	a_rol: assert property (p_rol) else $error("rotate left wrong"); // see RULE_05

	property p_asr;
		@(posedge i_clk) disable iff (!i_rst_b)
		(take && op == bsf_pkg::OP_ARITH_SHIFT_RIGHT) |=>
			(o_result == {$past(i_rd[7]), $past(i_rd[7:1])});
	endproperty
	a_asr: assert property (p_asr) else $error("arith shift wrong"); // see RULE_07

	property p_swap;
		@(posedge i_clk) disable iff (!i_rst_b)
		(take && op == bsf_pkg::OP_NIBBLE_SWAP) |=> ($stable(status_reg)
			&& o_result == {$past(i_rd[3:0]), $past(i_rd[7:4])});
	endproperty
	a_swap: assert property (p_swap) else $error("nibble swap wrong"); // see RULE_08

	property p_bst;
		@(posedge i_clk) disable iff (!i_rst_b)
		(take && op == bsf_pkg::OP_BIT_TO_FLAG_COPY) |=>
			(o_status_register[bsf_pkg::FLAG_T] == $past(i_rd[i_bit]));
	endproperty
	a_bst: assert property (p_bst) else $error("bit store wrong"); // see RULE_13

	property p_quiet;
		@(posedge i_clk) disable iff (!i_rst_b)
		(take && (op == bsf_pkg::OP_NOP || op == bsf_pkg::OP_WATCHDOG_RESTART))
			|=> ($stable(status_reg) && !o_result_we && o_done);
	endproperty
	a_quiet: assert property (p_quiet) else $error("quiet op changed state"); // see RULE_19

	property p_wdr;
		@(posedge i_clk) disable iff (!i_rst_b)
		(take && op == bsf_pkg::OP_WATCHDOG_RESTART) |=> o_watchdog_restart
			##1 (o_watchdog_restart == $past(take && op == bsf_pkg::OP_WATCHDOG_RESTART));
	endproperty
	a_wdr: assert property (p_wdr) else $error("watchdog pulse wrong"); // see RULE_16

	property p_ror;
		@(posedge i_clk) disable iff (!i_rst_b)
		(take && op == bsf_pkg::OP_ROTATE_RIGHT_CARRY) |=> (o_result_we
			&& o_result == {$past(status_reg[bsf_pkg::FLAG_C]), $past(i_rd[7:1])}
			&& o_status_register[bsf_pkg::FLAG_C] == $past(i_rd[0]));
	endproperty
	a_ror: assert property (p_ror) else $error("rotate right wrong"); // see RULE_06

	// Masks instead of a variable index keep the check simple for every tool
	property p_bld;
		@(posedge i_clk) disable iff (!i_rst_b)
		(take && op == bsf_pkg::OP_FLAG_TO_BIT_COPY) |=> ($stable(status_reg) && o_result_we
			&& ((o_result ^ $past(i_rd)) & ~$past(bit_mask)) == 8'h00
			&& (o_result & $past(bit_mask))
			== ($past(status_reg[bsf_pkg::FLAG_T]) ? $past(bit_mask) : 8'h00));
	endproperty
	a_bld: assert property (p_bld) else $error("bit load wrong"); // see RULE_14

	property p_ovf_clr;
		@(posedge i_clk) disable iff (!i_rst_b)
		(take && op == bsf_pkg::OP_OVERFLOW_FLAG_CLEAR) |=> (o_done
			&& o_status_register == ($past(status_reg) & ~(8'h01 << bsf_pkg::FLAG_V)));
	endproperty
	a_ovf_clr: assert property (p_ovf_clr) else $error("overflow clear wrong"); // see RULE_11

	property p_sleep;
		@(posedge i_clk) disable iff (!i_rst_b)
		(take && op == bsf_pkg::OP_SLEEP) |=> (o_sleep_req && o_done && $stable(status_reg)
			&& !o_result_we);
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep request wrong"); // see RULE_15
endmodule : bsf_unit

// *** test_bsf_unit.sv ***
// Self-checking testbench for the bit, shift and flag execution unit
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
	$display("mismatch %s expected %h seen %h", nm, e, g); end end
module test_bsf_unit;
	logic i_clk = 1'b0;
	logic i_rst_b;
	logic i_valid;
	logic [4:0] i_op;
	logic [7:0] i_rd;
	logic [2:0] i_bit;
	logic [7:0] i_io_data;
	logic o_ready, o_done, o_result_we, o_io_we;
	logic [7:0] o_result, o_io_data, o_status_register;
	logic o_sleep_req, o_watchdog_restart, o_debug_break;
	int fail_count = 0;
	int n_tests = 0;
	int cycles = 0;
	logic [7:0] st;
	logic [7:0] vals [5] = '{8'h81, 8'h80, 8'h01, 8'h00, 8'h7e};

	bsf_unit bsf_unit_inst (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_valid(i_valid), .i_op(i_op),
		.i_rd(i_rd), .i_bit(i_bit), .i_io_data(i_io_data), .o_ready(o_ready), .o_done(o_done),
		.o_result(o_result), .o_result_we(o_result_we), .o_io_data(o_io_data),
		.o_io_we(o_io_we), .o_status_register(o_status_register), .o_sleep_req(o_sleep_req),
		.o_watchdog_restart(o_watchdog_restart), .o_debug_break(o_debug_break));

	always #50 i_clk = ~i_clk;

	// ==========================================================
	// Verdict and hang guard
	task finish_test;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : finish_test

	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			finish_test();
		end
	end

	// ==========================================================
	// One operation with its expected outcome
	// Poke raises a second request while the unit is busy; it must be ignored
	task run(input bsf_pkg::bsf_op_e op, input logic [7:0] rd, input logic [2:0] b,
		input logic [7:0] io, input logic poke);
		logic [7:0] r;
		logic [7:0] s;
		logic [7:0] nio;
		logic we;
		logic iw;
		int n;
		r = rd;
		s = st;
		nio = io;
		we = 1'b1;
		iw = 1'b0;
		case (op)
			bsf_pkg::OP_IO_BIT_SET: begin nio[b] = 1'b1; iw = 1'b1; we = 1'b0; end
			bsf_pkg::OP_IO_BIT_CLEAR: begin nio[b] = 1'b0; iw = 1'b1; we = 1'b0; end
			bsf_pkg::OP_LOGICAL_SHIFT_LEFT: begin r = {rd[6:0], 1'b0}; s[0] = rd[7]; end
			bsf_pkg::OP_LOGICAL_SHIFT_RIGHT: begin r = {1'b0, rd[7:1]}; s[0] = rd[0]; end
			bsf_pkg::OP_ROTATE_LEFT_CARRY: begin r = {rd[6:0], st[0]}; s[0] = rd[7]; end
			bsf_pkg::OP_ROTATE_RIGHT_CARRY: begin r = {st[0], rd[7:1]}; s[0] = rd[0]; end
			bsf_pkg::OP_ARITH_SHIFT_RIGHT: begin r = {rd[7], rd[7:1]}; s[0] = rd[0]; end
			bsf_pkg::OP_NIBBLE_SWAP: r = {rd[3:0], rd[7:4]};
			bsf_pkg::OP_FLAG_TO_BIT_COPY: r[b] = st[6];
			default: we = 1'b0;
		endcase
		case (op)
			bsf_pkg::OP_STATUS_BIT_SET: s[b] = 1'b1;
			bsf_pkg::OP_STATUS_BIT_CLEAR: s[b] = 1'b0;
			bsf_pkg::OP_BIT_TO_FLAG_COPY: s[6] = rd[b];
			bsf_pkg::OP_SIGN_FLAG_SET: s[4] = 1'b1;
			bsf_pkg::OP_SIGN_FLAG_CLEAR: s[4] = 1'b0;
			bsf_pkg::OP_OVERFLOW_FLAG_CLEAR: s[3] = 1'b0;
			bsf_pkg::OP_HALF_CARRY_SET: s[5] = 1'b1;
			bsf_pkg::OP_HALF_CARRY_CLEAR: s[5] = 1'b0;
			bsf_pkg::OP_INT_ENABLE: s[7] = 1'b1;
			bsf_pkg::OP_INT_DISABLE: s[7] = 1'b0;
			default: ;
		endcase
		// Shift flags: V follows N xor C, S follows N xor V
		if (op >= bsf_pkg::OP_LOGICAL_SHIFT_LEFT && op <= bsf_pkg::OP_ARITH_SHIFT_RIGHT) begin
			s[1] = (r == 8'h00);
			s[2] = r[7];
			s[3] = r[7] ^ s[0];
			s[4] = s[2] ^ s[3];
		end
		@(negedge i_clk);
		i_valid = 1'b1;
		i_op = op;
		i_rd = rd;
		i_bit = b;
		i_io_data = io;
		@(negedge i_clk);
		i_valid = poke;
		i_op = bsf_pkg::OP_HALF_CARRY_SET;
		n = 1;
		if (iw) `CHK("ready", 1'b0, o_ready)
		while (o_done !== 1'b1 && n < 8) begin
			@(negedge i_clk);
			i_valid = 1'b0;
			n++;
		end
		i_valid = 1'b0;
		`CHK("latency", iw ? bsf_pkg::IO_BIT_CYCLES : 1, n)
		`CHK("status", s, o_status_register)
		`CHK("result_we", we, o_result_we)
		if (we) `CHK("result", r, o_result)
		`CHK("sleep", op == bsf_pkg::OP_SLEEP, o_sleep_req)
		`CHK("wdr", op == bsf_pkg::OP_WATCHDOG_RESTART, o_watchdog_restart)
		`CHK("break", op == bsf_pkg::OP_DEBUG_BREAK, o_debug_break)
		// The new I/O value goes out together with the completion pulse
		`CHK("io_we", iw, o_io_we)
		if (iw) begin
			`CHK("io_data", nio, o_io_data)
			@(negedge i_clk);
			`CHK("io_we", 1'b0, o_io_we)
			`CHK("status", s, o_status_register)
		end
		st = s;
	endtask : run

	// ==========================================================
	// Main sequence
	initial begin
		i_rst_b = 1'b0;
		i_valid = 1'b0;
		i_op = 5'h00;
		i_rd = 8'h00;
		i_bit = 3'h0;
		i_io_data = 8'h00;
		st = bsf_pkg::STATUS_RESET;
		repeat (8) @(negedge i_clk);
		i_rst_b = 1'b1;
		`CHK("ready", 1'b1, o_ready)
		`CHK("status", bsf_pkg::STATUS_RESET, o_status_register)
		`CHK("done", 1'b0, o_done)
		for (int i = 0; i < 8; i++) run(bsf_pkg::OP_STATUS_BIT_SET, 8'h00, 3'(i), 8'h00, 1'b0);
		run(bsf_pkg::OP_OVERFLOW_FLAG_CLEAR, 8'h00, 3'h0, 8'h00, 1'b0);
		run(bsf_pkg::OP_SIGN_FLAG_CLEAR, 8'h00, 3'h0, 8'h00, 1'b0);
		run(bsf_pkg::OP_HALF_CARRY_CLEAR, 8'h00, 3'h0, 8'h00, 1'b0);
		run(bsf_pkg::OP_INT_DISABLE, 8'h00, 3'h0, 8'h00, 1'b0);
		for (int i = 0; i < 8; i++) run(bsf_pkg::OP_STATUS_BIT_CLEAR, 8'h00, 3'(i), 8'h00, 1'b0);
		run(bsf_pkg::OP_SIGN_FLAG_SET, 8'h00, 3'h0, 8'h00, 1'b0);
		run(bsf_pkg::OP_HALF_CARRY_SET, 8'h00, 3'h0, 8'h00, 1'b0);
		run(bsf_pkg::OP_INT_ENABLE, 8'h00, 3'h0, 8'h00, 1'b0);
		for (int j = 3; j < 8; j++) begin
			for (int k = 0; k < 5; k++) begin
				run(bsf_pkg::bsf_op_e'(j), vals[k], 3'h0, 8'h00, 1'b0);
			end
		end
		run(bsf_pkg::OP_NIBBLE_SWAP, 8'ha5, 3'h0, 8'h00, 1'b0);
		for (int i = 0; i < 8; i++) begin
			run(bsf_pkg::OP_BIT_TO_FLAG_COPY, 8'h5a, 3'(i), 8'h00, 1'b0);
			run(bsf_pkg::OP_FLAG_TO_BIT_COPY, 8'h0f, 3'(i), 8'h00, 1'b0);
		end
		run(bsf_pkg::OP_IO_BIT_SET, 8'h00, 3'h7, 8'h00, 1'b1);
		run(bsf_pkg::OP_IO_BIT_SET, 8'h00, 3'h0, 8'h55, 1'b0);
		run(bsf_pkg::OP_IO_BIT_CLEAR, 8'h00, 3'h0, 8'hff, 1'b1);
		run(bsf_pkg::OP_IO_BIT_CLEAR, 8'h00, 3'h7, 8'h80, 1'b0);
		run(bsf_pkg::OP_NOP, 8'h3c, 3'h0, 8'h00, 1'b0);
		run(bsf_pkg::OP_SLEEP, 8'h00, 3'h0, 8'h00, 1'b0);
		run(bsf_pkg::OP_WATCHDOG_RESTART, 8'h00, 3'h0, 8'h00, 1'b0);
		run(bsf_pkg::OP_DEBUG_BREAK, 8'h00, 3'h0, 8'h00, 1'b0);
		finish_test();
	end
endmodule : test_bsf_unit
